// file: sfp_regs.svh
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ==================================================
// Register offsets (byte addresses)
`define SFP_OFS_CMD      5'h00
`define SFP_OFS_ZPTR     5'h04
`define SFP_OFS_DATA     5'h08
`define SFP_OFS_STORE    5'h0c
`define SFP_OFS_LOAD     5'h10

// ==================================================
// Command register fields
`define SFP_BIT_IE       7
`define SFP_BIT_BUSY     6
`define SFP_CMD_RESET    5'h00
`define SFP_PAT_LOAD     5'h01
`define SFP_PAT_ERASE    5'h03
`define SFP_PAT_WRITE    5'h05
`define SFP_PAT_LOCK     5'h09
`define SFP_PAT_REEN     5'h11

// ==================================================
// Address pointer fields and fuse selectors
`define SFP_PAGE_LSB     6
`define SFP_WORD_LSB     1
`define SFP_SEL_FUSE_LO  2'h0
`define SFP_SEL_LOCK     2'h1
`define SFP_SEL_FUSE_EX  2'h2
`define SFP_SEL_FUSE_HI  2'h3
`define SFP_LOCK_KEEP    8'hc3
`define SFP_LOCK_INIT    8'hff

// ==================================================
// Timing
`define SFP_STORE_WIN    3'h4
`define SFP_LOAD_WIN_MIN 3'h2
`define SFP_CLK_HZ       10000000
`define SFP_OP_TIME_US   4500
`define SFP_OP_CYCLES    (`SFP_OP_TIME_US * (`SFP_CLK_HZ / 1000000))

`endif

// file: sfp_pkg.sv
package sfp_pkg;

  typedef enum logic [1:0] {
    SFP_IDLE,
    SFP_ARMED,
    SFP_BUSY
  } sfp_state_t;

  typedef struct packed {
    sfp_state_t  st;
    logic        ie;
    logic        busy;
    logic [4:0]  cmd;
    logic [2:0]  win;
    logic [15:0] timer;
    logic [6:0]  page;
    logic        no_read_while_write_section;
    logic        wr_op;
    logic [15:0] zptr;
    logic [15:0] data;
    logic [7:0]  lock;
    logic        waitreq;
    logic [31:0] rdata;
    logic        halt;
    logic        irq;
    logic        erase_p;
    logic        write_p;
  } sfp_ctl_t;

endpackage

// file: sfp_buf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfp_buf_if #(
  parameter int WORD_W = 5
);
  logic              ld;
  logic              clr;
  logic [WORD_W-1:0] waddr;
  logic [15:0]       wdata;
  logic [WORD_W-1:0] raddr;
  logic [15:0]       rdata;

  modport ctl (output ld, output clr, output waddr, output wdata, output raddr, input rdata);
  modport store (input ld, input clr, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// file: sfp_page_buf.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_page_buf #(
  parameter int WORD_W = 5
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Controller side
  sfp_buf_if.store  bus
);
  localparam int WORDS = 1 << WORD_W;

  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
  } sfp_buf_st_t;

  sfp_buf_st_t s_r;
  sfp_buf_st_t s_nxt;

  // ==================================================
  // Clear beats load in the same cycle
  always_comb begin
    s_nxt = s_r;
    if (bus.clr) begin
      s_nxt.mem = '0;
    end else if (bus.ld) begin
      s_nxt.mem[bus.waddr] = bus.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.rdata = s_r.mem[bus.raddr];
endmodule
`default_nettype wire

// file: sfp_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.svh"
module sfp_sequencer #(
  parameter int          PAGE_W          = 7,
  parameter int          WORD_W          = 5,
  parameter int          NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 96,
  parameter int          OP_CYCLES       = `SFP_OP_CYCLES,
  parameter logic [7:0]  FUSE_LOW        = 8'hff,
  parameter logic [7:0]  FUSE_HIGH       = 8'hff,
  parameter logic [7:0]  FUSE_EXT        = 8'hff
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Avalon-MM slave
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // EEPROM status
  input  wire logic        eeprom_write_busy_i,
  input  wire logic        eeprom_write_start_i,
  // Flash array and core
  output logic             flash_erase_o,
  output logic             flash_write_o,
  output logic [6:0]       flash_page_o,
  output logic             cpu_halt_o,
  output logic             rww_block_o,
  output logic             prog_ready_irq_o,
  output logic [7:0]       lock_bits_o
);
  sfp_pkg::sfp_ctl_t s_r;
  sfp_pkg::sfp_ctl_t s_nxt;

  sfp_buf_if #(.WORD_W(WORD_W)) buf_bus ();

  sfp_page_buf #(.WORD_W(WORD_W)) u_buf (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .bus     (buf_bus.store)
  );

  // ==================================================
  // Helpers
  function automatic logic pat_valid(input logic [4:0] p);
    pat_valid = (p == `SFP_PAT_LOAD) || (p == `SFP_PAT_ERASE) || (p == `SFP_PAT_WRITE) ||
                (p == `SFP_PAT_LOCK) || (p == `SFP_PAT_REEN);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  function automatic logic [7:0] fuse_sel(input logic [1:0] sel, input logic [7:0] lock);
    case (sel)
      `SFP_SEL_FUSE_LO: fuse_sel = FUSE_LOW;
      `SFP_SEL_LOCK:    fuse_sel = lock;
      `SFP_SEL_FUSE_EX: fuse_sel = FUSE_EXT;
      default:          fuse_sel = FUSE_HIGH;
    endcase
  endfunction

  // ==================================================
  // Decode
  logic       req;
  logic       acc;
  logic       cmd_wr;
  logic       store_go;
  logic       lpm_mode;
  logic       lpm_go;
  logic [6:0] page_sel;

  assign req      = read_i | write_i;
  assign acc      = req & ~s_r.waitreq;
  assign cmd_wr   = acc & write_i & (address_i == `SFP_OFS_CMD) & byteenable_i[0];
  assign store_go = acc & write_i & (address_i == `SFP_OFS_STORE) &
                    (s_r.st == sfp_pkg::SFP_ARMED) & ~eeprom_write_busy_i;
  // Fuse reads refused while EEPROM busy; plain buffer read instead
  assign lpm_mode = (s_r.st == sfp_pkg::SFP_ARMED) & (s_r.cmd == `SFP_PAT_LOCK) &
                    (s_r.win >= `SFP_LOAD_WIN_MIN) & ~eeprom_write_busy_i;
  assign lpm_go   = acc & read_i & (address_i == `SFP_OFS_LOAD) & lpm_mode;
  assign page_sel = 7'(s_r.zptr[`SFP_PAGE_LSB +: PAGE_W]);

  assign buf_bus.raddr = s_r.zptr[`SFP_WORD_LSB +: WORD_W];
  assign buf_bus.waddr = s_r.zptr[`SFP_WORD_LSB +: WORD_W];
  assign buf_bus.wdata = s_r.data;

  // ==================================================
  // Read mux, evaluated when the request is first seen
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_i)
      `SFP_OFS_CMD:  rd_mux = {24'h00_0000, s_r.ie, s_r.busy, 1'b0, s_r.cmd};
      `SFP_OFS_ZPTR: rd_mux = {16'h0000, s_r.zptr};
      `SFP_OFS_DATA: rd_mux = {16'h0000, s_r.data};
      `SFP_OFS_LOAD: begin
        if (lpm_mode) begin
          rd_mux = {24'h00_0000, fuse_sel(s_r.zptr[1:0], s_r.lock)};
        end else begin
          rd_mux = {16'h0000, buf_bus.rdata};
        end
      end
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // ==================================================
  // Next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.erase_p = 1'b0;
    s_nxt.write_p = 1'b0;
    buf_bus.ld   = 1'b0;
    buf_bus.clr  = 1'b0;

    // Bus handshake: one wait cycle, then one ready cycle
    if (req && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata   = rd_mux;
    end else begin
      s_nxt.waitreq = 1'b1;
    end

    case (s_r.st)
      sfp_pkg::SFP_IDLE: begin
        s_nxt.cmd = `SFP_CMD_RESET;
      end
      sfp_pkg::SFP_ARMED: begin
        if (store_go) begin
          case (s_r.cmd)
            `SFP_PAT_LOAD: begin
              buf_bus.ld = 1'b1;
              s_nxt.busy = 1'b0;
              s_nxt.cmd  = `SFP_CMD_RESET;
              s_nxt.st   = sfp_pkg::SFP_IDLE;
            end
            `SFP_PAT_ERASE, `SFP_PAT_WRITE: begin
              // Page latched so the pointer is free during the operation
              s_nxt.page    = page_sel;
              s_nxt.no_read_while_write_section    = (page_sel >= 7'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE));
              s_nxt.halt    = (page_sel >= 7'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE));
              s_nxt.busy    = (page_sel < 7'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)) | s_r.busy;
              s_nxt.wr_op   = (s_r.cmd == `SFP_PAT_WRITE);
              s_nxt.erase_p = (s_r.cmd == `SFP_PAT_ERASE);
              s_nxt.write_p = (s_r.cmd == `SFP_PAT_WRITE);
              s_nxt.timer   = 16'(OP_CYCLES);
              s_nxt.st      = sfp_pkg::SFP_BUSY;
            end
            `SFP_PAT_LOCK: begin
              // Whole flash stays readable: no halt, no block
              s_nxt.lock  = s_r.lock & (s_r.data[7:0] | `SFP_LOCK_KEEP);
              s_nxt.wr_op = 1'b0;
              s_nxt.timer = 16'(OP_CYCLES);
              s_nxt.st    = sfp_pkg::SFP_BUSY;
            end
            default: begin
              s_nxt.busy  = 1'b0;
              buf_bus.clr = 1'b1;
              s_nxt.cmd   = `SFP_CMD_RESET;
              s_nxt.st    = sfp_pkg::SFP_IDLE;
            end
          endcase
        end else if (lpm_go) begin
          s_nxt.cmd = `SFP_CMD_RESET;
          s_nxt.st  = sfp_pkg::SFP_IDLE;
        end else if (s_r.win == 3'h1) begin
          s_nxt.cmd = `SFP_CMD_RESET;
          s_nxt.st  = sfp_pkg::SFP_IDLE;
        end else begin
          s_nxt.win = s_r.win - 3'h1;
        end
      end
      sfp_pkg::SFP_BUSY: begin
        if (s_r.timer == 16'h0001) begin
          s_nxt.cmd  = `SFP_CMD_RESET;
          s_nxt.halt = 1'b0;
          s_nxt.st   = sfp_pkg::SFP_IDLE;
          if (s_r.wr_op) begin
            buf_bus.clr = 1'b1;
          end
        end else begin
          s_nxt.timer = s_r.timer - 16'h0001;
        end
      end
      default: begin
        s_nxt.st  = sfp_pkg::SFP_IDLE;
        s_nxt.cmd = `SFP_CMD_RESET;
      end
    endcase

    // EEPROM write aborts a buffer fill in progress
    if (eeprom_write_start_i && s_r.st != sfp_pkg::SFP_BUSY) begin
      buf_bus.clr = 1'b1;
    end

    // Register writes
    if (cmd_wr) begin
      s_nxt.ie = writedata_i[`SFP_BIT_IE];
      if (s_r.st == sfp_pkg::SFP_IDLE && !eeprom_write_busy_i &&
          pat_valid(writedata_i[4:0])) begin
        s_nxt.cmd = writedata_i[4:0];
        s_nxt.win = `SFP_STORE_WIN;
        s_nxt.st  = sfp_pkg::SFP_ARMED;
      end
    end
    if (acc && write_i && address_i == `SFP_OFS_ZPTR) begin
      s_nxt.zptr = merge16(s_r.zptr, writedata_i, byteenable_i);
    end
    if (acc && write_i && address_i == `SFP_OFS_DATA) begin
      s_nxt.data = merge16(s_r.data, writedata_i, byteenable_i);
    end

    s_nxt.irq = s_nxt.ie & ~s_nxt.cmd[0];
  end

  // ==================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r         <= '0;
      s_r.st      <= sfp_pkg::SFP_IDLE;
      s_r.lock    <= `SFP_LOCK_INIT;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign readdata_o       = s_r.rdata;
  assign waitrequest_o    = s_r.waitreq;
  assign flash_erase_o    = s_r.erase_p;
  assign flash_write_o    = s_r.write_p;
  assign flash_page_o     = s_r.page;
  assign cpu_halt_o       = s_r.halt;
  assign rww_block_o      = s_r.busy;
  assign prog_ready_irq_o = s_r.irq;
  assign lock_bits_o      = s_r.lock;

  // ==================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence seq_arm(logic [4:0] p);
    cmd_wr && s_r.st == sfp_pkg::SFP_IDLE && !eeprom_write_busy_i && writedata_i[4:0] == p;
  endsequence

  sequence seq_op_go;
    store_go && (s_r.cmd == `SFP_PAT_ERASE || s_r.cmd == `SFP_PAT_WRITE);
  endsequence

  AST_ERASE_START: assert property (
    seq_arm(`SFP_PAT_ERASE) |=> (s_r.st == sfp_pkg::SFP_ARMED && s_r.win == 3'h4))
    else $error("erase pattern did not arm a four cycle window");

  AST_RWW_BLOCK: assert property (
    (seq_op_go and (page_sel < 7'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE))) |=> rww_block_o && !cpu_halt_o)
    else $error("far section not blocked during programming");

  AST_NO_READ_WHILE_WRITE_SECTION_HALT: assert property (
    (seq_op_go and (page_sel >= 7'(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE))) |=>
      cpu_halt_o && flash_page_o == $past(page_sel))
    else $error("core not halted for near section operation");

  AST_ENABLE_HOLD: assert property (
    s_r.st == sfp_pkg::SFP_BUSY && s_r.timer != 16'h0001 |=> s_r.cmd[0] && $stable(s_r.cmd))
    else $error("enable dropped during operation");

  AST_READY_IRQ: assert property (
    s_r.ie && !s_r.cmd[0] && !cmd_wr && s_r.st == sfp_pkg::SFP_IDLE |=> prog_ready_irq_o)
    else $error("ready request not held");

  AST_EE_REJECT: assert property (
    cmd_wr && eeprom_write_busy_i && s_r.st == sfp_pkg::SFP_IDLE |=> s_r.st == sfp_pkg::SFP_IDLE)
    else $error("command accepted during EEPROM write");

  AST_WIN_CLOSE: assert property (
    s_r.st == sfp_pkg::SFP_ARMED && s_r.win == 3'h1 && !store_go |=> s_r.cmd == 5'h00)
    else $error("store window did not close after four cycles");

  AST_BAD_PATTERN: assert property (
    cmd_wr && !pat_valid(writedata_i[4:0]) && s_r.st == sfp_pkg::SFP_IDLE |=>
      $stable(s_r.cmd) && $stable(s_r.st))
    else $error("invalid pattern had an effect");

  AST_LOAD_CLEARS_BUSY: assert property (
    store_go && s_r.cmd == `SFP_PAT_LOAD |-> buf_bus.ld ##1 !rww_block_o)
    else $error("buffer load did not clear busy flag");

  AST_LOCK_SET: assert property (
    store_go && s_r.cmd == `SFP_PAT_LOCK |=>
      lock_bits_o == ($past(s_r.lock) & ($past(s_r.data[7:0]) | 8'hc3)))
    else $error("lock bits not programmed from low data");

  AST_WRITE_CLEARS_BUF: assert property (
    s_r.st == sfp_pkg::SFP_BUSY && s_r.timer == 16'h0001 && s_r.wr_op |-> buf_bus.clr)
    else $error("buffer not cleared after page write");
endmodule
`default_nettype wire

// file: sfp_core_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.svh"
// ==================================================
// Boot loader core: Avalon-MM master
module sfp_core_model (
  // Clock
  input  wire logic        clk_i,
  // Avalon-MM master
  output logic [4:0]       address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o,
  output logic [3:0]       byteenable_o,
  input  wire logic [31:0] readdata_i,
  input  wire logic        waitrequest_i,
  // EEPROM status
  input  wire logic        eeprom_write_busy_i
);
  initial begin
    address_o <= 5'h00;
    read_o <= 1'b0;
    write_o <= 1'b0;
    writedata_o <= 32'h0;
    byteenable_o <= 4'hf;
  end

  // Call right after a rising edge; returns one edge after release
  // Only register traffic, never a fetch from the blocked section
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] m, output logic [31:0] q);
    address_o <= a;
    writedata_o <= d;
    byteenable_o <= m;
    write_o <= w;
    read_o <= !w;
    do begin
      @(posedge clk_i);
    end while (waitrequest_i !== 1'b0);
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    // Released lines must not keep looking valid
    address_o <= ~a;
    writedata_o <= ~d;
    @(posedge clk_i);
  endtask

  // Command then store, inside the four-cycle window
  task automatic cmd_store(input logic [7:0] c);
    logic [31:0] q;
    while (eeprom_write_busy_i !== 1'b0) begin
      @(posedge clk_i);
    end
    xfer(1'b1, `SFP_OFS_CMD, {24'h0, c}, 4'hf, q);
    xfer(1'b1, `SFP_OFS_STORE, 32'h0, 4'hf, q);
  endtask
endmodule
`default_nettype wire

// file: tb_flash_self_program_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfp_regs.svh"
module tb_flash_self_program_sequencer;
  localparam logic [7:0] FL = 8'h5a;
  localparam logic [7:0] FH = 8'ha5;
  localparam logic [7:0] FE = 8'hf1;
  logic        clk_i = 1'b0;
  logic        reset_i;
  logic [4:0]  address;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        ee_busy;
  logic        ee_start;
  logic        flash_erase_o;
  logic        flash_write_o;
  logic [6:0]  flash_page_o;
  logic        cpu_halt_o;
  logic        rww_block_o;
  logic        prog_ready_irq_o;
  logic [7:0]  lock_bits_o;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_ers = 0;
  int          n_wr = 0;
  int          seed = 70899;

  always #50 clk_i = ~clk_i;

  sfp_sequencer #(.OP_CYCLES(8), .FUSE_LOW(FL), .FUSE_HIGH(FH), .FUSE_EXT(FE)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .address_i(address), .read_i(rd), .write_i(wr),
    .writedata_i(wdata), .byteenable_i(be), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .eeprom_write_busy_i(ee_busy),
    .eeprom_write_start_i(ee_start), .flash_erase_o(flash_erase_o),
    .flash_write_o(flash_write_o), .flash_page_o(flash_page_o), .cpu_halt_o(cpu_halt_o),
    .rww_block_o(rww_block_o), .prog_ready_irq_o(prog_ready_irq_o),
    .lock_bits_o(lock_bits_o));

  sfp_core_model core (
    .clk_i(clk_i), .address_o(address), .read_o(rd), .write_o(wr), .writedata_o(wdata),
    .byteenable_o(be), .readdata_i(readdata_o), .waitrequest_i(waitrequest_o),
    .eeprom_write_busy_i(ee_busy));

  always @(posedge clk_i) begin
    if (flash_erase_o === 1'b1) n_ers++;
    if (flash_write_o === 1'b1) n_wr++;
  end

  function automatic logic [7:0] lock_exp(input logic [7:0] prev, input logic [7:0] d);
    return prev & (d | 8'hc3);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    // Upper lanes random: the design must ignore them
    core.xfer(1'b1, a, d, {2'($random(seed)), 2'b11}, q);
  endtask

  task automatic rreg(input logic [4:0] a, output logic [31:0] q);
    core.xfer(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task automatic op_wait();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rreg(`SFP_OFS_CMD, q);
      n++;
    end while (q[0] !== 1'b0);
  endtask

  // Word readback at a buffer index
  task automatic buf_chk(input logic [4:0] idx, input logic [15:0] exp);
    logic [31:0] q;
    wreg(`SFP_OFS_ZPTR, {26'h0, idx, 1'b0});
    rreg(`SFP_OFS_LOAD, q);
    check("buf_word", q, {16'h0, exp});
  endtask

  task automatic load(input logic [4:0] idx, input logic [15:0] w);
    wreg(`SFP_OFS_ZPTR, {26'h0, idx, 1'b0});
    wreg(`SFP_OFS_DATA, {16'h0, w});
    core.cmd_store(8'h01);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    $display("[ERR] watchdog expected finish seen hang");
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic [15:0] mem [4];
    logic [4:0]  idx [4];
    logic [4:0]  b;
    logic [7:0]  d;
    logic [7:0]  lk;
    logic [7:0]  bad [5];
    logic [7:0]  sel_exp [4];
    bad = '{8'h07, 8'h1f, 8'h02, 8'h13, 8'h0d};
    reset_i <= 1'b1;
    ee_busy <= 1'b0;
    ee_start <= 1'b0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    // ==================================================
    // Reset state
    check("waitreq_idle", waitrequest_o, 1);
    rreg(`SFP_OFS_CMD, q);
    check("cmd_reset", q, 0);
    check("lock_reset", lock_bits_o, 8'hff);
    // Byte lane merge on the pointer
    wreg(`SFP_OFS_ZPTR, 32'h0000_1234);
    core.xfer(1'b1, `SFP_OFS_ZPTR, 32'h0000_ab99, 4'h2, q);
    rreg(`SFP_OFS_ZPTR, q);
    check("zptr_lanes", q, 32'h0000_ab34);
    $display("test reset done");
    // ==================================================
    // Erase a far-section page with ready request on
    wreg(`SFP_OFS_ZPTR, 32'h5 << 6);
    core.cmd_store(8'h83);
    check("block_erase", rww_block_o, 1);
    check("halt_far", cpu_halt_o, 0);
    check("irq_busy", prog_ready_irq_o, 0);
    rreg(`SFP_OFS_CMD, q);
    check("cmd_busy", q, 32'hc3);
    op_wait();
    rreg(`SFP_OFS_CMD, q);
    check("cmd_done", q, 32'hc0);
    check("irq_done", prog_ready_irq_o, 1);
    check("n_erase", n_ers, 1);
    check("erase_page", flash_page_o, 7'd5);
    core.cmd_store(8'h11);
    check("block_reen", rww_block_o, 0);
    $display("test erase done");
    // ==================================================
    // Fill buffer at random distinct words, then write
    b = 5'($random(seed));
    for (int k = 0; k < 4; k++) begin
      idx[k] = b + 5'(k * 5);
      mem[k] = 16'($random(seed));
      load(idx[k], mem[k]);
    end
    for (int k = 0; k < 4; k++) buf_chk(idx[k], mem[k]);
    wreg(`SFP_OFS_ZPTR, 32'h5 << 6);
    core.cmd_store(8'h05);
    check("block_write", rww_block_o, 1);
    check("halt_write", cpu_halt_o, 0);
    op_wait();
    check("n_write", n_wr, 1);
    buf_chk(idx[0], 16'h0);
    load(idx[1], mem[1]);
    check("block_load", rww_block_o, 0);
    buf_chk(idx[1], mem[1]);
    ee_start <= 1'b1;
    @(posedge clk_i);
    ee_start <= 1'b0;
    @(posedge clk_i);
    buf_chk(idx[1], 16'h0);
    $display("test page write done");
    // ==================================================
    // Near-section erase halts the core
    wreg(`SFP_OFS_ZPTR, 32'd100 << 6);
    core.cmd_store(8'h03);
    check("halt_near", cpu_halt_o, 1);
    op_wait();
    check("halt_end", cpu_halt_o, 0);
    check("near_page", flash_page_o, 7'd100);
    $display("test near erase done");
    // ==================================================
    // Bad patterns and missed store window
    for (int k = 0; k < 5; k++) begin
      wreg(`SFP_OFS_CMD, {24'h0, bad[k]});
      rreg(`SFP_OFS_CMD, q);
      check("cmd_bad", q, 0);
    end
    wreg(`SFP_OFS_CMD, 32'h03);
    repeat (6) @(posedge clk_i);
    rreg(`SFP_OFS_CMD, q);
    check("cmd_timeout", q, 0);
    wreg(`SFP_OFS_STORE, 32'h0);
    check("n_erase_late", n_ers, 2);
    $display("test refusals done");
    // ==================================================
    // Lock set then lock and fuse reads
    d = 8'($random(seed)) | 8'hc3;
    lk = lock_exp(8'hff, d);
    wreg(`SFP_OFS_ZPTR, 32'h1);
    wreg(`SFP_OFS_DATA, {24'h0, d});
    core.cmd_store(8'h09);
    op_wait();
    check("lock_bits", lock_bits_o, lk);
    sel_exp = '{FL, lk, FE, FH};
    for (int k = 0; k < 4; k++) begin
      wreg(`SFP_OFS_ZPTR, k);
      wreg(`SFP_OFS_CMD, 32'h09);
      rreg(`SFP_OFS_LOAD, q);
      check("fuse_lock_rd", q, {24'h0, sel_exp[k]});
      rreg(`SFP_OFS_CMD, q);
      check("cmd_after_rd", q, 0);
    end
    $display("test lock done");
    // ==================================================
    // EEPROM busy blocks commands
    ee_busy <= 1'b1;
    wreg(`SFP_OFS_CMD, 32'h03);
    rreg(`SFP_OFS_CMD, q);
    check("cmd_ee_busy", q, 0);
    wreg(`SFP_OFS_STORE, 32'h0);
    check("n_erase_ee", n_ers, 2);
    ee_busy <= 1'b0;
    @(posedge clk_i);
    $display("test eeprom done");
    conclude();
  end
endmodule
`default_nettype wire
